//--- design/abtc_pkg.sv
// abtc_pkg: register map, field positions, reset values and mode codes
// of the 8-bit timer with one compare channel.
// assumes a 32-bit avalon-mm slave, one register per aligned word.
package abtc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL    = 8'hb0; // timer_control_a
  localparam logic [7:0] IDX_CNT    = 8'hb2; // count_value
  localparam logic [7:0] IDX_CMP    = 8'hb3; // compare_value
  localparam logic [7:0] IDX_ASYNC  = 8'hb6; // async_status
  localparam logic [7:0] IDX_FLAGS  = 8'hb7; // event flags, write one to clear

  // timer_control_a fields
  localparam int CTL_FORCE  = 7;
  localparam int CTL_WGM_LO = 6;
  localparam int CTL_COM_HI = 5;
  localparam int CTL_COM_LO = 4;
  localparam int CTL_WGM_HI = 3;
  localparam int CTL_CS_HI  = 2;
  localparam int CTL_CS_LO  = 0;

  // async_status fields
  localparam int AS_EXT_CLOCK_INPUT_ENABLE    = 4;
  localparam int AS_SEL      = 3;
  localparam int AS_CNT_PEND = 2;
  localparam int AS_CMP_PEND = 1;
  localparam int AS_CTL_PEND = 0;

  // flags fields
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP = 1;

  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] ASYNC_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET   = 8'h00;
  localparam logic [7:0] CMP_RESET   = 8'h00;
  localparam logic [7:0] CNT_MAX     = 8'hff;
  localparam logic [7:0] CNT_BOTTOM  = 8'h00;

  // oscillator edges from a write to its landing in the destination
  localparam logic [1:0] LATCH_EDGES = 2'h2;

  // prescaler masks: tick when the low bits of the prescale count are all ones
  localparam logic [9:0] PSC_M8    = 10'h007;
  localparam logic [9:0] PSC_M32   = 10'h01f;
  localparam logic [9:0] PSC_M64   = 10'h03f;
  localparam logic [9:0] PSC_M128  = 10'h07f;
  localparam logic [9:0] PSC_M256  = 10'h0ff;
  localparam logic [9:0] PSC_M1024 = 10'h3ff;

  // waveform modes as {upper bit, lower bit}
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PHASE  = 2'b01,
    MODE_CLEAR  = 2'b10,
    MODE_FAST   = 2'b11
  } abtc_mode_t;

  // output action codes
  typedef enum logic [1:0] {
    ACT_OFF    = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } abtc_act_t;

endpackage

//--- design/abtc_prescaler.sv
// abtc_prescaler: divides the timer source ticks and picks a rate.
// assumes src_tick is a one-cycle enable on clk.
`timescale 1ns/1ns
`default_nettype none
module abtc_prescaler
  import abtc_pkg::*;
#(
  parameter int PSC_W = 10
) (
  input  wire logic       clk,      // system clock
  input  wire logic       rstn,     // sync reset, active low
  input  wire logic       src_tick, // one tick of the timer source
  input  wire logic [2:0] sel,      // clock select code
  output logic            tick      // timer count enable
);

  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] mask;

  // free-running prescale count, advanced only by source ticks
  always_ff @(posedge clk) begin
    if (!rstn) begin
      psc_q <= '0;
    end else if (src_tick) begin
      psc_q <= psc_q + PSC_W'(1);
    end
  end

  // rate choice
  always_comb begin
    case (sel)
      3'h2:    mask = PSC_W'(PSC_M8);
      3'h3:    mask = PSC_W'(PSC_M32);
      3'h4:    mask = PSC_W'(PSC_M64);
      3'h5:    mask = PSC_W'(PSC_M128);
      3'h6:    mask = PSC_W'(PSC_M256);
      3'h7:    mask = PSC_W'(PSC_M1024);
      default: mask = '0;
    endcase
  end

  // code 000 stops, 001 passes every source tick
  always_comb begin
    if (sel == 3'h0) begin
      tick = 1'b0; // RULE14
    end else begin
      tick = src_tick && ((psc_q & mask) == mask); // RULE14
    end
  end

endmodule // abtc_prescaler
`default_nettype wire

//--- design/abtc_timer.sv
// What this block does
// [RULE1] force strobe fires compare action in non-pwm
// [RULE2] force strobe sets no flag, no clear
// [RULE3] force strobe always reads back zero
// [RULE4] software keeps force zero in pwm modes
// [RULE5] mode field picks sequence, top, waveform
// [RULE6] top, compare update and overflow point per mode
// [RULE7] nonzero action field takes over the pin
// [RULE8] software sets pin direction to output
// [RULE9] non-pwm match toggles, clears or sets
// [RULE10] fast pwm clear/set on match, reverse at bottom
// [RULE11] fast pwm compare at top acts at bottom
// [RULE12] phase pwm action depends on count direction
// [RULE13] phase pwm compare at top acts at top
// [RULE14] clock select stops, passes or divides source
// [RULE15] count register is read and writable
// [RULE16] count write blocks next compare match
// [RULE17] compare register matched continuously, flags, pin
// [RULE18] external clock buffer on, crystal off, per bit
// [RULE19] software sets external clock before async select
// [RULE20] async select moves timer to oscillator pin
// [RULE21] async writes raise pending bits until landed
// [RULE22] async writes land after two oscillator edges
// [RULE23] phase pwm counts up then down
//
// top of the timer: avalon-mm slave, counter, compare and waveform unit.
// assumes the oscillator pin is asynchronous to clk and far slower.
`timescale 1ns/1ns
`default_nettype none
module abtc_timer
  import abtc_pkg::*;
(
  input  wire logic        clk,                  // system clock, 100 MHz
  input  wire logic        rstn,                 // sync reset, active low
  input  wire logic [9:0]  address,              // avalon byte address
  input  wire logic        read,                 // avalon read
  input  wire logic        write,                // avalon write
  input  wire logic [31:0] writedata,            // avalon write data
  input  wire logic [3:0]  byteenable,           // avalon byte lanes
  output logic      [31:0] readdata,             // avalon read data
  output logic             waitrequest,          // avalon stall
  input  wire logic        timer_osc_input_pin,  // oscillator pin level
  output logic             compare_output_pin,   // waveform output value
  output logic             compare_pin_override, // waveform owns the pin
  output logic             ext_clk_buf_en,       // external clock buffer on
  output logic             xtal_osc_en           // crystal oscillator on
);

  // bus side
  logic        waitreq_q;
  logic [31:0] rdata_q;
  logic [7:0]  idx;
  logic        acc_wr;
  logic        wr_ctl, wr_cnt, wr_cmp, wr_async, wr_flags;
  logic [7:0]  rd_mux;

  // registers and temporaries
  logic [7:0]  ctl_q, ctl_tmp_q, cmp_tmp_q, cnt_tmp_q;
  logic        force_tmp_q;
  logic        ext_clock_input_enable_q, as_q;
  logic [2:0]  pend_q;
  logic [1:0]  edge_q [3];
  logic [1:0]  flags_q;

  // oscillator pin synchroniser
  logic        osc_s1_q, osc_s2_q, osc_s3_q;
  logic        osc_rise;

  // landing strobes into the destinations
  logic        land_ctl, land_cnt, land_cmp;
  logic [7:0]  land_ctl_v, land_cnt_v, land_cmp_v;
  logic        land_force;

  // counter and compare
  abtc_mode_t  mode, new_mode;
  abtc_act_t   act, new_act;
  logic [7:0]  cnt_q, cnt_d, cmp_buf_q, cmp_act_q;
  logic        down_q, down_d;
  logic        block_q;
  logic        src_tick, t_tick;
  logic        match_evt, ovf_evt;
  logic        oc_q, oc_d;
  logic        ovr_q, extb_q, xtal_q;

  assign idx      = address[9:2];
  assign mode     = abtc_mode_t'({ctl_q[CTL_WGM_HI], ctl_q[CTL_WGM_LO]}); // RULE5
  assign act      = abtc_act_t'(ctl_q[CTL_COM_HI:CTL_COM_LO]);
  assign new_mode = abtc_mode_t'({land_ctl_v[CTL_WGM_HI], land_ctl_v[CTL_WGM_LO]});
  assign new_act  = abtc_act_t'(land_ctl_v[CTL_COM_HI:CTL_COM_LO]);

  // avalon slave
  // one stall cycle per request; the answer stands while waitrequest is low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end else if ((read || write) && waitreq_q) begin
      waitreq_q <= 1'b0;
      rdata_q   <= read ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  // write takes effect only at the edge that sees waitrequest low
  assign acc_wr   = write && !waitreq_q && byteenable[0];
  assign wr_ctl   = acc_wr && (idx == IDX_CTL);
  assign wr_cnt   = acc_wr && (idx == IDX_CNT);
  assign wr_cmp   = acc_wr && (idx == IDX_CMP);
  assign wr_async = acc_wr && (idx == IDX_ASYNC);
  assign wr_flags = acc_wr && (idx == IDX_FLAGS);

  // read mux; control and compare read their temporaries, count reads live
  always_comb begin
    case (idx)
      IDX_CTL:   rd_mux = {1'b0, ctl_tmp_q[6:0]}; // RULE3
      IDX_CNT:   rd_mux = cnt_q; // RULE15
      IDX_CMP:   rd_mux = cmp_tmp_q;
      IDX_ASYNC: rd_mux = {3'h0, ext_clock_input_enable_q, as_q, pend_q}; // RULE21
      IDX_FLAGS: rd_mux = {6'h00, flags_q};
      default:   rd_mux = 8'h00;
    endcase
  end

  // oscillator pin
  // only the second stage reads the first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= timer_osc_input_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_rise = osc_s2_q && !osc_s3_q;

  // async select and external clock enable; switching may corrupt state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ext_clock_input_enable_q <= ASYNC_RESET[AS_EXT_CLOCK_INPUT_ENABLE];
      as_q    <= ASYNC_RESET[AS_SEL];
    end else if (wr_async) begin
      ext_clock_input_enable_q <= writedata[AS_EXT_CLOCK_INPUT_ENABLE];
      as_q    <= writedata[AS_SEL]; // RULE20
    end
  end

  // temporaries and pending bits
  // software-side copies, each written by a bus write to its own register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctl_tmp_q   <= CTL_RESET;
      cmp_tmp_q   <= CMP_RESET;
      cnt_tmp_q   <= CNT_RESET;
      force_tmp_q <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_tmp_q   <= writedata[7:0];
        force_tmp_q <= writedata[CTL_FORCE];
      end else if (land_ctl) begin
        force_tmp_q <= 1'b0; // strobe is consumed once
      end
      if (wr_cmp) begin
        cmp_tmp_q <= writedata[7:0];
      end
      if (wr_cnt) begin
        cnt_tmp_q <= writedata[7:0];
      end
    end
  end

  // pending per register; a new write restarts its own edge count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        edge_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (as_q && ((i == AS_CNT_PEND && wr_cnt) || (i == AS_CMP_PEND && wr_cmp)
                     || (i == AS_CTL_PEND && wr_ctl))) begin
          pend_q[i] <= 1'b1; // RULE21
          edge_q[i] <= 2'h0;
        end else if (pend_q[i] && osc_rise) begin
          if (edge_q[i] == LATCH_EDGES - 2'h1) begin
            pend_q[i] <= 1'b0; // RULE22
            edge_q[i] <= 2'h0;
          end else begin
            edge_q[i] <= edge_q[i] + 2'h1;
          end
        end
      end
    end
  end

  // landing: at once when synchronous, on the second oscillator edge when async
  always_comb begin
    if (as_q) begin
      land_ctl = pend_q[AS_CTL_PEND] && osc_rise
                 && (edge_q[AS_CTL_PEND] == LATCH_EDGES - 2'h1); // RULE22
      land_cnt = pend_q[AS_CNT_PEND] && osc_rise
                 && (edge_q[AS_CNT_PEND] == LATCH_EDGES - 2'h1);
      land_cmp = pend_q[AS_CMP_PEND] && osc_rise
                 && (edge_q[AS_CMP_PEND] == LATCH_EDGES - 2'h1);
      land_ctl_v = ctl_tmp_q;
      land_cnt_v = cnt_tmp_q;
      land_cmp_v = cmp_tmp_q;
      land_force = force_tmp_q;
    end else begin
      land_ctl   = wr_ctl;
      land_cnt   = wr_cnt;
      land_cmp   = wr_cmp;
      land_ctl_v = writedata[7:0];
      land_cnt_v = writedata[7:0];
      land_cmp_v = writedata[7:0];
      land_force = writedata[CTL_FORCE];
    end
  end

  // destination control register; the strobe bit is never stored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctl_q <= CTL_RESET;
    end else if (land_ctl) begin
      ctl_q <= {1'b0, land_ctl_v[6:0]}; // RULE3
    end
  end

  // timer clock; async mode counts synchronised pin rises
  assign src_tick = as_q ? osc_rise : 1'b1; // RULE20

  abtc_prescaler #(
    .PSC_W (10)
  ) u_psc (
    .clk      (clk),
    .rstn     (rstn),
    .src_tick (src_tick),
    .sel      (ctl_q[CTL_CS_HI:CTL_CS_LO]),
    .tick     (t_tick)
  );

  // counter
  // a count write masks the match for exactly one timer tick
  assign match_evt = t_tick && (cnt_q == cmp_act_q) && !block_q; // RULE16 RULE17
  assign ovf_evt   = t_tick && ((mode == MODE_PHASE) ? (down_q && cnt_q == CNT_BOTTOM)
                                                    : (cnt_q == CNT_MAX)); // RULE6

  // next count per mode
  always_comb begin
    cnt_d  = cnt_q + 8'h01;
    down_d = down_q;
    case (mode)
      MODE_CLEAR: begin
        if (match_evt) begin
          cnt_d = CNT_BOTTOM; // RULE6
        end
      end
      MODE_PHASE: begin
        if (!down_q && cnt_q == CNT_MAX) begin
          down_d = 1'b1; // RULE23
          cnt_d  = cnt_q - 8'h01;
        end else if (down_q && cnt_q == CNT_BOTTOM) begin
          down_d = 1'b0; // RULE23
        end else if (down_q) begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: cnt_d = cnt_q + 8'h01; // normal and fast wrap past max
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q  <= CNT_RESET;
      down_q <= 1'b0;
    end else if (land_cnt) begin
      cnt_q <= land_cnt_v; // RULE15
    end else if (t_tick) begin
      cnt_q  <= cnt_d;
      down_q <= (mode == MODE_PHASE) ? down_d : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      block_q <= 1'b0;
    end else if (land_cnt) begin
      block_q <= 1'b1; // RULE16
    end else if (t_tick) begin
      block_q <= 1'b0;
    end
  end

  // compare register
  // pwm modes double-buffer so a mid-period write cannot glitch the wave
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_buf_q <= CMP_RESET;
      cmp_act_q <= CMP_RESET;
    end else begin
      if (land_cmp) begin
        cmp_buf_q <= land_cmp_v;
      end
      if (mode == MODE_NORMAL || mode == MODE_CLEAR) begin
        cmp_act_q <= land_cmp ? land_cmp_v : cmp_buf_q; // RULE6
      end else if (t_tick && cnt_q == CNT_MAX && !down_q) begin
        cmp_act_q <= cmp_buf_q; // RULE6
      end
    end
  end

  // event flags: hardware set beats a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= 2'h0;
    end else begin
      flags_q[FLG_OVF] <= ovf_evt || (flags_q[FLG_OVF] && !(wr_flags && writedata[FLG_OVF]));
      flags_q[FLG_CMP] <= match_evt // RULE2 RULE17
                          || (flags_q[FLG_CMP] && !(wr_flags && writedata[FLG_CMP]));
    end
  end

  // waveform unit
  always_comb begin
    oc_d = oc_q;
    if (t_tick) begin
      case (mode)
        MODE_FAST: begin
          if (act[1] && cnt_q == CNT_MAX) begin
            oc_d = (act == ACT_CLEAR); // RULE10 RULE11
          end else if (act[1] && match_evt && cmp_act_q != CNT_MAX) begin
            oc_d = (act == ACT_SET); // RULE10
          end
        end
        MODE_PHASE: begin
          if (act[1] && cmp_act_q == CNT_MAX) begin
            if (!down_q && cnt_q == CNT_MAX) begin
              oc_d = (act == ACT_SET); // RULE13
            end
          end else if (act[1] && match_evt) begin
            oc_d = down_q ? (act == ACT_CLEAR) : (act == ACT_SET); // RULE12
          end
        end
        default: begin
          if (match_evt) begin
            case (act)
              ACT_TOGGLE: oc_d = !oc_q; // RULE9
              ACT_CLEAR:  oc_d = 1'b0;
              ACT_SET:    oc_d = 1'b1;
              default:    oc_d = oc_q;
            endcase
          end
        end
      endcase
    end
    // forced compare uses the newly landed action bits, ignored in pwm
    if (land_ctl && land_force && !new_mode[0]) begin
      case (new_act)
        ACT_TOGGLE: oc_d = !oc_q; // RULE1
        ACT_CLEAR:  oc_d = 1'b0;
        ACT_SET:    oc_d = 1'b1;
        default:    oc_d = oc_q;
      endcase
    end
  end

  // pin and oscillator controls, all registered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oc_q   <= 1'b0;
      ovr_q  <= 1'b0;
      extb_q <= 1'b0;
      xtal_q <= 1'b0;
    end else begin
      oc_q   <= oc_d;
      ovr_q  <= (act != ACT_OFF); // RULE7
      extb_q <= ext_clock_input_enable_q && as_q; // RULE18
      xtal_q <= as_q && !ext_clock_input_enable_q; // RULE18
    end
  end

  assign readdata             = rdata_q;
  assign waitrequest          = waitreq_q;
  assign compare_output_pin   = oc_q;
  assign compare_pin_override = ovr_q;
  assign ext_clk_buf_en       = extb_q;
  assign xtal_osc_en          = xtal_q;

  // checks
  a_force_reads_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE3
    (read && !waitreq_q && idx == IDX_CTL) |-> rdata_q[CTL_FORCE] == 1'b0)
    else $error("force strobe read back as one");

  a_force_toggles_pin: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    (land_ctl && land_force && !new_mode[0] && new_act == ACT_TOGGLE && !t_tick)
    |=> oc_q != $past(oc_q))
    else $error("forced toggle did not change the pin");

  a_force_pwm_inert: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    (land_ctl && land_force && new_mode[0] && !t_tick) |=> $stable(oc_q))
    else $error("force changed pin in pwm mode");

  a_force_no_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE2
    (land_ctl && land_force && !t_tick && !land_cnt && !flags_q[FLG_CMP])
    |=> !flags_q[FLG_CMP] && $stable(cnt_q))
    else $error("force set a flag or moved the count");

  a_ctc_clears: assert property (@(posedge clk) disable iff (!rstn) // RULE6
    (mode == MODE_CLEAR && match_evt && !land_cnt) |=> cnt_q == CNT_BOTTOM)
    else $error("clear-on-match did not clear");

  a_write_blocks: assert property (@(posedge clk) disable iff (!rstn) // RULE16
    (t_tick && block_q && !wr_flags) |=> flags_q[FLG_CMP] == $past(flags_q[FLG_CMP]))
    else $error("match not suppressed after count write");

  a_phase_turns: assert property (@(posedge clk) disable iff (!rstn) // RULE23
    (t_tick && mode == MODE_PHASE && !down_q && cnt_q == CNT_MAX && !land_cnt)
    |=> down_q && cnt_q == 8'hfe)
    else $error("phase mode did not turn at top");

  a_pin_owner: assert property (@(posedge clk) disable iff (!rstn) // RULE7
    ##1 compare_pin_override == ($past(act) != ACT_OFF))
    else $error("pin override disagrees with action bits");

  a_pend_sets: assert property (@(posedge clk) disable iff (!rstn) // RULE21
    (as_q && wr_cmp) |=> pend_q[AS_CMP_PEND])
    else $error("compare pending bit not raised");

  a_pend_edges: assert property (@(posedge clk) disable iff (!rstn) // RULE22
    $fell(pend_q[AS_CMP_PEND]) |-> $past(osc_rise) && $past(edge_q[AS_CMP_PEND]) == 2'h1)
    else $error("compare landed without two oscillator edges");

  a_stop_no_tick: assert property (@(posedge clk) disable iff (!rstn) // RULE14
    (ctl_q[CTL_CS_HI:CTL_CS_LO] == 3'h0) |-> !t_tick)
    else $error("timer ticked while stopped");

  a_ext_buffer: assert property (@(posedge clk) disable iff (!rstn) // RULE18
    ##1 (ext_clk_buf_en == $past(ext_clock_input_enable_q && as_q)) && !(ext_clk_buf_en && xtal_osc_en))
    else $error("oscillator controls wrong");

  c_fast_wrap: cover property (@(posedge clk) disable iff (!rstn)
    t_tick && mode == MODE_FAST && cnt_q == CNT_MAX);
  c_phase_bottom: cover property (@(posedge clk) disable iff (!rstn)
    ovf_evt && mode == MODE_PHASE);
  c_async_land: cover property (@(posedge clk) disable iff (!rstn) as_q && land_ctl);
  c_forced: cover property (@(posedge clk) disable iff (!rstn) land_ctl && land_force);

endmodule // abtc_timer
`default_nettype wire

//--- verification/abtc_timer_test.sv
// abtc_timer_test: self-checking bench for the 8-bit compare timer.
// assumes the bench alone drives the avalon port and the oscillator pin.
`timescale 1ns/1ns
`default_nettype none
module abtc_timer_test
  import abtc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn, read, write, osc;
  logic [9:0]  address;
  logic [31:0] writedata, readdata, rv;
  logic [3:0]  byteenable;
  logic        waitrequest, pin, ovr, bufen, xtal;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          hi;
  logic [7:0]  fc [4] = '{8'h90, 8'h90, 8'hb0, 8'ha0};
  logic        fe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int          dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0]  ac [3] = '{8'h10, 8'h18, 8'h08};
  logic [1:0]  ae [3] = '{2'b00, 2'b10, 2'b01};
  logic [7:0]  pc [6] = '{8'h61, 8'h71, 8'h69, 8'h79, 8'h69, 8'h61};
  logic [7:0]  pm [6] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hff, 8'hff};
  int          pw [6] = '{510, 510, 512, 512, 512, 510};
  int          px [6] = '{128, 382, 130, 382, 512, 0};

  abtc_timer dut (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timer_osc_input_pin(osc), .compare_output_pin(pin),
    .compare_pin_override(ovr), .ext_clk_buf_en(bufen), .xtal_osc_en(xtal));

  // 100 MHz clock
  always #5 clk = ~clk;

  // hang guard, far above the ~20k cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; held until waitrequest is seen low at an edge
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    address   <= {idx, 2'b00};
    writedata <= {24'h00_0000, d};
    read      <= ~wr;
    write     <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rv = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk); // gap so a following request is not raised in the same step
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(rv, {24'h00_0000, exp});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // main sequence
  initial begin
    rstn       = 1'b0;
    read       = 1'b0;
    write      = 1'b0;
    osc        = 1'b0;
    address    = 10'h000;
    writedata  = 32'h0000_0000;
    byteenable = 4'hf;
    wt(5);
    rstn <= 1'b1;
    @(posedge clk);
    rdchk(IDX_CTL, 8'h00);
    rdchk(IDX_ASYNC, 8'h00);
    rdchk(8'hb1, 8'h00);
    $display("test reset done");

    // forced matches walk toggle, set and clear with the timer stopped
    foreach (fc[i]) begin
      bus(IDX_CTL, 1'b1, fc[i]);
      wt(2);
      chk({30'h0, ovr, pin}, {30'h0, 1'b1, fe[i]});
    end
    rdchk(IDX_CTL, 8'h20);
    bus(IDX_CTL, 1'b1, 8'h00);
    wt(2);
    chk({31'h0, ovr}, 32'h0);
    bus(IDX_CTL, 1'b1, 8'hf8);
    wt(2);
    chk({31'h0, pin}, 32'h0);
    bus(IDX_CTL, 1'b1, 8'h00);
    bus(IDX_CNT, 1'b1, 8'h5a);
    bus(IDX_CTL, 1'b1, 8'h98);
    rdchk(IDX_CNT, 8'h5a);
    rdchk(IDX_FLAGS, 8'h00);
    $display("test force done");

    // normal then clear-on-match runs, then a blocked match
    bus(IDX_CTL, 1'b1, 8'h00);
    bus(IDX_CMP, 1'b1, 8'h40);
    bus(IDX_CNT, 1'b1, 8'h00);
    bus(IDX_CTL, 1'b1, 8'h21);
    wt(300);
    bus(IDX_CTL, 1'b1, 8'h00);
    rdchk(IDX_FLAGS, 8'h03);
    chk({31'h0, pin}, 32'h0);
    bus(IDX_FLAGS, 1'b1, 8'h03);
    bus(IDX_CNT, 1'b1, 8'h00);
    bus(IDX_CTL, 1'b1, 8'h39);
    wt(300);
    bus(IDX_CTL, 1'b1, 8'h00);
    rdchk(IDX_FLAGS, 8'h02);
    chk({31'h0, pin}, 32'h1);
    bus(IDX_CNT, 1'b0, 8'h00);
    chk({31'h0, rv[7:0] <= 8'h40}, 32'h1);
    bus(IDX_FLAGS, 1'b1, 8'h03);
    bus(IDX_CMP, 1'b1, 8'h20);
    bus(IDX_CNT, 1'b1, 8'h20);
    bus(IDX_CTL, 1'b1, 8'h01);
    wt(3);
    bus(IDX_CTL, 1'b1, 8'h00);
    rdchk(IDX_FLAGS, 8'h00);
    $display("test count done");

    // every prescale code counts about eight ticks in eight periods
    for (int c = 1; c < 8; c++) begin
      bus(IDX_CNT, 1'b1, 8'h00);
      bus(IDX_CTL, 1'b1, {5'h00, c[2:0]});
      wt(8 * dv[c]);
      bus(IDX_CTL, 1'b1, 8'h00);
      bus(IDX_CNT, 1'b0, 8'h00);
      chk({31'h0, rv[7:0] inside {[8'h07:8'h0c]}}, 32'h1);
    end
    wt(50);
    rdchk(IDX_CNT, rv[7:0]);
    $display("test prescale done");

    // clock source outputs, external enable set before async select
    foreach (ac[i]) begin
      bus(IDX_ASYNC, 1'b1, ac[i]);
      wt(2);
      chk({30'h0, bufen, xtal}, {30'h0, ae[i]});
    end
    // oscillator pin runs only here, 400 ns period
    bus(IDX_CMP, 1'b1, 8'h33);
    rdchk(IDX_ASYNC, 8'h0a);
    repeat (2) begin wt(20); osc <= ~osc; end
    wt(10);
    rdchk(IDX_ASYNC, 8'h0a);
    repeat (2) begin wt(20); osc <= ~osc; end
    wt(10);
    rdchk(IDX_ASYNC, 8'h08);
    rdchk(IDX_CMP, 8'h33);
    bus(IDX_ASYNC, 1'b1, 8'h00);
    $display("test async done");

    // pwm duty over one phase period or two fast periods, both polarities and compare at top
    foreach (pc[i]) begin
      bus(IDX_CTL, 1'b1, 8'h00);
      bus(IDX_CMP, 1'b1, pm[i]);
      bus(IDX_CNT, 1'b1, 8'h00);
      bus(IDX_CTL, 1'b1, pc[i]);
      wt(600);
      hi = 0;
      repeat (pw[i]) begin @(posedge clk); hi += (pin === 1'b1); end
      chk({31'h0, hi >= px[i] - 5 && hi <= px[i] + 5}, 32'h1);
    end
    $display("test pwm done");
    test_done();
  end
endmodule // abtc_timer_test
`default_nettype wire
